// [src/gpbc_pin_stage.sv]
// Pin driver and input synchroniser for one port
`timescale 1ns/1ps
module gpbc_pin_stage import gpbc_pkg::*; #(
   parameter int WIDTH = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   gpbc_port_if.pins port,
   input wire logic [WIDTH-1:0] i_pin,
   output logic [WIDTH-1:0] o_pin,
   output logic [WIDTH-1:0] o_pin_oe
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] sync;

   // ----------------------------------------------------------------
   // Two-stage input synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         meta <= '0;
         sync <= '0;
      end else begin
         meta <= i_pin;
         sync <= meta;
      end
   end
   assign port.pin_sync = sync;

   // ----------------------------------------------------------------
   // Output drive
   // ----------------------------------------------------------------
   // Open-drain only pulls low; a latch one releases the pin
   // Unavailable lines never drive, whatever software wrote
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_pin <= '0;
         o_pin_oe <= '0;
      end else begin
         o_pin <= port.latch & ~port.open_drain;
         o_pin_oe <= ~port.direction & port.enable_mask & ~(port.open_drain & port.latch);
      end
   end
endmodule : gpbc_pin_stage

// [src/gpbc_pkg.sv]
// Types shared by the port B/C block
package gpbc_pkg;
   // Package variant, smallest to largest
   typedef enum logic [1:0] {
      GPBC_PKG_SMALL = 2'h0,
      GPBC_PKG_MID = 2'h1,
      GPBC_PKG_LARGE = 2'h2
   } gpbc_pkg_e;

   // Bus slave state
   typedef enum logic [2:0] {
      GPBC_ST_IDLE = 3'b001,
      GPBC_ST_ACK = 3'b010,
      GPBC_ST_WAIT = 3'b100
   } gpbc_state_e;

   typedef logic [15:0] gpbc_word_t;
endpackage : gpbc_pkg

// [src/gpbc_port_if.sv]
// Interface carrying one port's register state to its pin stage
`timescale 1ns/1ps
interface gpbc_port_if #(parameter int WIDTH = 16);
   logic [WIDTH-1:0] direction;
   logic [WIDTH-1:0] latch;
   logic [WIDTH-1:0] open_drain;
   logic [WIDTH-1:0] enable_mask;
   logic [WIDTH-1:0] pin_sync;
   modport regs (output direction, output latch, output open_drain, output enable_mask, input pin_sync);
   modport pins (input direction, input latch, input open_drain, input enable_mask, output pin_sync);
endinterface : gpbc_port_if

// [src/gpbc_port_regs.sv]
// Direction, latch and open-drain registers of one port
`timescale 1ns/1ps
`include "gpbc_regs.svh"
module gpbc_port_regs import gpbc_pkg::*; #(
   parameter int WIDTH = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic [WIDTH-1:0] i_mask,
   input wire logic i_wr_dir,
   input wire logic i_wr_lat,
   input wire logic i_wr_od,
   input wire logic [WIDTH-1:0] i_wdata,
   input wire logic [WIDTH-1:0] i_wstrb,
   output logic [WIDTH-1:0] o_direction,
   output logic [WIDTH-1:0] o_latch,
   output logic [WIDTH-1:0] o_open_drain
);
   logic [WIDTH-1:0] wbits;

   // Only implemented, byte-enabled bits change
   assign wbits = i_wstrb & i_mask;

   // ----------------------------------------------------------------
   // Direction: all inputs after reset
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_direction <= WIDTH'(`GPBC_RST_DIRECTION);
      end else if (i_wr_dir) begin
         o_direction <= (o_direction & ~wbits) | (i_wdata & wbits);
      end
   end

   // Latch: written through either pin-state or latch address
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_latch <= WIDTH'(`GPBC_RST_LATCH);
      end else if (i_wr_lat) begin
         o_latch <= (o_latch & ~wbits) | (i_wdata & wbits);
      end
   end

   // Open-drain: cleared on reset
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_open_drain <= WIDTH'(`GPBC_RST_OPEN_DRAIN);
      end else if (i_wr_od) begin
         o_open_drain <= (o_open_drain & ~wbits) | (i_wdata & wbits);
      end
   end
endmodule : gpbc_port_regs

// [src/gpbc_regs.svh]
// Register offsets, field positions, reset values and port C masks for the port B/C block
`ifndef GPBC_REGS_SVH
`define GPBC_REGS_SVH

// ----------------------------------------------------------------
// Register word indices (the byte address is four times the index)
// ----------------------------------------------------------------
`define GPBC_IDX_B_DIRECTION 12'h2C8
`define GPBC_IDX_B_PIN_STATE 12'h2CA
`define GPBC_IDX_B_OUTPUT_LATCH 12'h2CC
`define GPBC_IDX_B_OPEN_DRAIN 12'h2CE
`define GPBC_IDX_C_DIRECTION 12'h2D0
`define GPBC_IDX_C_PIN_STATE 12'h2D2
`define GPBC_IDX_C_OUTPUT_LATCH 12'h2D4
`define GPBC_IDX_C_OPEN_DRAIN 12'h2D6
`define GPBC_IDX_CONFIG 12'h2F0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPBC_RST_DIRECTION 16'hFFFF
`define GPBC_RST_OPEN_DRAIN 16'h0000
`define GPBC_RST_LATCH 16'h0000

// ----------------------------------------------------------------
// Port C implemented-bit masks per package
// ----------------------------------------------------------------
`define GPBC_C_MASK_LARGE 16'hF01E
`define GPBC_C_MASK_MID 16'hF00A
`define GPBC_C_MASK_SMALL 16'hF000
`define GPBC_C_LINE12 4'd12
`define GPBC_C_LINE15 4'd15

// ----------------------------------------------------------------
// Configuration register fields and codes
// ----------------------------------------------------------------
`define GPBC_CFG_OSC_MODE_LSB 0
`define GPBC_CFG_PIN_FN_LSB 2
`define GPBC_CFG_PKG_LSB 4
`define GPBC_OSC_MODE_OFF 2'h3
`define GPBC_OSC_MODE_EXT 2'h0
`define GPBC_PIN_FN_IO 2'h3
`define GPBC_RST_CONFIG 6'h3F

`endif

// [src/gpbc_top.sv]
// Two general-purpose I/O ports (B and C) behind a classic Wishbone slave
// Functional notes
// - Unimplemented port bits read zero and ignore writes.
// - Reset sets all direction bits to one and clears open-drain bits.
// - Port C lines 12 and 15 work only with oscillator mode 11 or 00.
// - Port C line 15 also needs oscillator pin function field equal 11.
// - Some port C bits exist only in the largest package.
// - Further port C bits are absent only in the smallest package.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "gpbc_regs.svh"
module gpbc_top import gpbc_pkg::*; #(
   parameter int WIDTH = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [13:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic [WIDTH-1:0] i_port_b,
   output logic [WIDTH-1:0] o_port_b,
   output logic [WIDTH-1:0] o_port_b_oe,
   input wire logic [WIDTH-1:0] i_port_c,
   output logic [WIDTH-1:0] o_port_c,
   output logic [WIDTH-1:0] o_port_c_oe
);
   gpbc_port_if #(.WIDTH(WIDTH)) b_if ();
   gpbc_port_if #(.WIDTH(WIDTH)) c_if ();

   gpbc_state_e state;
   logic [5:0] config_reg;
   logic [1:0] primary_osc_mode_cfg;
   logic [1:0] osc_pin_function_cfg;
   gpbc_pkg_e pkg_sel;
   logic [WIDTH-1:0] c_pkg_mask;
   logic [WIDTH-1:0] c_mask;
   logic line12_ok;
   logic line15_ok;
   logic [11:0] idx;
   logic req;
   logic wr;
   logic [WIDTH-1:0] wstrb;
   logic [WIDTH-1:0] io_b_direction;
   logic [WIDTH-1:0] io_b_output_latch;
   logic [WIDTH-1:0] io_b_open_drain;
   logic [WIDTH-1:0] io_c_direction;
   logic [WIDTH-1:0] io_c_output_latch;
   logic [WIDTH-1:0] io_c_open_drain;
   logic [WIDTH-1:0] io_b_pin_state;
   logic [WIDTH-1:0] io_c_pin_state;
   logic [31:0] next_rdata;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Word index sits above the two byte bits
   assign idx = i_wb_adr[13:2];
   assign req = i_wb_cyc & i_wb_stb & (state == GPBC_ST_IDLE);
   assign wr = req & i_wb_we;
   // Only the low two lanes carry data; upper lanes are ignored
   assign wstrb = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

   // Single-cycle ack, then one idle cycle before the next request
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         state <= GPBC_ST_IDLE;
      end else begin
         case (state)
            GPBC_ST_IDLE: begin
               if (req) begin
                  state <= GPBC_ST_ACK;
               end
            end
            GPBC_ST_ACK: begin
               state <= GPBC_ST_WAIT;
            end
            GPBC_ST_WAIT: begin
               state <= GPBC_ST_IDLE;
            end
            default: begin
               state <= GPBC_ST_IDLE;
            end
         endcase
      end
   end
   assign o_wb_ack = (state == GPBC_ST_ACK);

   // ----------------------------------------------------------------
   // Configuration register (oscillator fields and package)
   // ----------------------------------------------------------------
   // Reset default enables every line, largest package
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         config_reg <= `GPBC_RST_CONFIG;
      end else if (wr && idx == `GPBC_IDX_CONFIG && i_wb_sel[0]) begin
         config_reg <= i_wb_dat[5:0];
      end
   end
   assign primary_osc_mode_cfg = config_reg[`GPBC_CFG_OSC_MODE_LSB +: 2];
   assign osc_pin_function_cfg = config_reg[`GPBC_CFG_PIN_FN_LSB +: 2];
   // Code 3 has no package; treat it as the largest
   assign pkg_sel = (config_reg[`GPBC_CFG_PKG_LSB +: 2] == 2'h3) ? GPBC_PKG_LARGE
                                                               : gpbc_pkg_e'(config_reg[`GPBC_CFG_PKG_LSB +: 2]);

   // ----------------------------------------------------------------
   // Port C availability
   // ----------------------------------------------------------------
   always_comb begin
      case (pkg_sel)
         GPBC_PKG_SMALL: c_pkg_mask = WIDTH'(`GPBC_C_MASK_SMALL);
         GPBC_PKG_MID: c_pkg_mask = WIDTH'(`GPBC_C_MASK_MID);
         GPBC_PKG_LARGE: c_pkg_mask = WIDTH'(`GPBC_C_MASK_LARGE);
         default: c_pkg_mask = WIDTH'(`GPBC_C_MASK_LARGE);
      endcase
   end

   // Lines 12 and 15 are shared with the oscillator pins
   assign line12_ok = (primary_osc_mode_cfg == `GPBC_OSC_MODE_OFF) ||
                      (primary_osc_mode_cfg == `GPBC_OSC_MODE_EXT);
   assign line15_ok = line12_ok && (osc_pin_function_cfg == `GPBC_PIN_FN_IO);

   always_comb begin
      c_mask = c_pkg_mask;
      c_mask[`GPBC_C_LINE12] = c_pkg_mask[`GPBC_C_LINE12] & line12_ok;
      c_mask[`GPBC_C_LINE15] = c_pkg_mask[`GPBC_C_LINE15] & line15_ok;
   end

   // ----------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------
   // Pin-state writes land in the latch, like latch writes
   gpbc_port_regs #(.WIDTH(WIDTH)) u_regs_b (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_mask({WIDTH{1'b1}}),
      .i_wr_dir(wr && idx == `GPBC_IDX_B_DIRECTION),
      .i_wr_lat(wr && (idx == `GPBC_IDX_B_OUTPUT_LATCH || idx == `GPBC_IDX_B_PIN_STATE)),
      .i_wr_od(wr && idx == `GPBC_IDX_B_OPEN_DRAIN),
      .i_wdata(i_wb_dat[WIDTH-1:0]),
      .i_wstrb(wstrb),
      .o_direction(io_b_direction),
      .o_latch(io_b_output_latch),
      .o_open_drain(io_b_open_drain)
   );

   // Port C writes are masked by the package only, so lines 12 and 15
   // keep their settings while the oscillator borrows the pins
   gpbc_port_regs #(.WIDTH(WIDTH)) u_regs_c (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_mask(c_pkg_mask),
      .i_wr_dir(wr && idx == `GPBC_IDX_C_DIRECTION),
      .i_wr_lat(wr && (idx == `GPBC_IDX_C_OUTPUT_LATCH || idx == `GPBC_IDX_C_PIN_STATE)),
      .i_wr_od(wr && idx == `GPBC_IDX_C_OPEN_DRAIN),
      .i_wdata(i_wb_dat[WIDTH-1:0]),
      .i_wstrb(wstrb),
      .o_direction(io_c_direction),
      .o_latch(io_c_output_latch),
      .o_open_drain(io_c_open_drain)
   );

   assign b_if.direction = io_b_direction;
   assign b_if.latch = io_b_output_latch;
   assign b_if.open_drain = io_b_open_drain;
   assign b_if.enable_mask = {WIDTH{1'b1}};
   assign c_if.direction = io_c_direction;
   assign c_if.latch = io_c_output_latch;
   assign c_if.open_drain = io_c_open_drain;
   assign c_if.enable_mask = c_mask;

   // ----------------------------------------------------------------
   // Pin stages
   // ----------------------------------------------------------------
   gpbc_pin_stage #(.WIDTH(WIDTH)) u_pins_b (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .port(b_if),
      .i_pin(i_port_b),
      .o_pin(o_port_b),
      .o_pin_oe(o_port_b_oe)
   );

   gpbc_pin_stage #(.WIDTH(WIDTH)) u_pins_c (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .port(c_if),
      .i_pin(i_port_c),
      .o_pin(o_port_c),
      .o_pin_oe(o_port_c_oe)
   );

   assign io_b_pin_state = b_if.pin_sync;
   // Unavailable port C lines read zero
   assign io_c_pin_state = c_if.pin_sync & c_mask;

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Unmapped addresses read zero and still ack, so software never hangs
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (idx)
         `GPBC_IDX_B_DIRECTION: next_rdata[WIDTH-1:0] = io_b_direction;
         `GPBC_IDX_B_PIN_STATE: next_rdata[WIDTH-1:0] = io_b_pin_state;
         `GPBC_IDX_B_OUTPUT_LATCH: next_rdata[WIDTH-1:0] = io_b_output_latch;
         `GPBC_IDX_B_OPEN_DRAIN: next_rdata[WIDTH-1:0] = io_b_open_drain;
         `GPBC_IDX_C_DIRECTION: next_rdata[WIDTH-1:0] = io_c_direction & c_mask;
         `GPBC_IDX_C_PIN_STATE: next_rdata[WIDTH-1:0] = io_c_pin_state;
         `GPBC_IDX_C_OUTPUT_LATCH: next_rdata[WIDTH-1:0] = io_c_output_latch & c_mask;
         `GPBC_IDX_C_OPEN_DRAIN: next_rdata[WIDTH-1:0] = io_c_open_drain & c_mask;
         `GPBC_IDX_CONFIG: next_rdata[5:0] = config_reg;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data registered with the request edge, valid with ack
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_wb_dat <= 32'h0000_0000;
      end else if (req) begin
         o_wb_dat <= i_wb_we ? 32'h0000_0000 : next_rdata;
      end
   end
endmodule : gpbc_top

// [verif/gpbc_top_props.sv]
// Concurrent checks on the port B/C block, seen from its top-level ports
`timescale 1ns/1ps
`include "gpbc_regs.svh"
module gpbc_top_props import gpbc_pkg::*; #(
   parameter int WIDTH = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [13:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic [WIDTH-1:0] i_port_b,
   input wire logic [WIDTH-1:0] o_port_b,
   input wire logic [WIDTH-1:0] o_port_b_oe,
   input wire logic [WIDTH-1:0] i_port_c,
   input wire logic [WIDTH-1:0] o_port_c,
   input wire logic [WIDTH-1:0] o_port_c_oe
);
   // ------------------------------------------------------------
   // Clocking, reset and helpers
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_b);
   logic req;
   // A request is live while cycle and strobe are both up
   assign req = i_wb_cyc & i_wb_stb;

   // ------------------------------------------------------------
   // Bus handshake and read data
   // ------------------------------------------------------------
   a_ack_single_pulse: assert property (o_wb_ack |=> !o_wb_ack [*2])
      else $error("ack held or repeated too soon");
   a_ack_after_take: assert property ($rose(req) |=> o_wb_ack)
      else $error("no ack one cycle after a taken request");
   a_ack_has_cause: assert property (o_wb_ack |-> $past(req))
      else $error("ack without a request");
   a_rdata_stands: assert property ($changed(o_wb_dat) |-> o_wb_ack)
      else $error("read data moved between transfers");
   a_upper_read_zero: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000)
      else $error("upper read half not zero");

   // ------------------------------------------------------------
   // Pins: absent bits never drive, reset floats every pin
   // ------------------------------------------------------------
   a_c_absent_quiet: assert property (((o_port_c | o_port_c_oe) & ~`GPBC_C_MASK_LARGE) == 16'h0000)
      else $error("absent port C bit is driven");
   // Checked through reset itself, so the default disable is overridden
   a_reset_inputs: assert property (disable iff (1'b0) !i_rst_b |=> (o_port_b_oe | o_port_c_oe) == 16'h0000 && !o_wb_ack)
      else $error("pins driven or ack during reset");
   // Pin outputs only move one edge after a register write lands
   a_pins_follow_write: assert property ($changed({o_port_b, o_port_b_oe, o_port_c, o_port_c_oe}) |-> $past(o_wb_ack & i_wb_we))
      else $error("pin outputs changed without a write");

   c_write: cover property ($rose(req) && i_wb_we);
   c_read: cover property (o_wb_ack && !i_wb_we);
   c_line15_drive: cover property (o_port_c_oe[15]);
   c_b_drive: cover property (o_port_b_oe != 16'h0000 && o_port_b != 16'h0000);
endmodule : gpbc_top_props

bind gpbc_top gpbc_top_props #(.WIDTH(WIDTH)) u_props (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
   .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_port_b(i_port_b), .o_port_b(o_port_b),
   .o_port_b_oe(o_port_b_oe), .i_port_c(i_port_c), .o_port_c(o_port_c), .o_port_c_oe(o_port_c_oe));

// [verif/gpbc_top_tb.sv]
// Self-checking bench for the port B/C register block
`timescale 1ns/1ps
`include "gpbc_regs.svh"
module gpbc_top_tb;
   logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [13:0] adr = 14'h0000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic [15:0] pb_in = 16'h0000, pc_in = 16'h0000, pb_out, pb_oe, pc_out, pc_oe, rd;
   int bad_count = 0, samples_checked = 0;

   // 200 MHz system clock
   always #2.5 clk = ~clk;

   gpbc_top #(.WIDTH(16)) DUT (.i_clk_sys(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_port_b(pb_in),
      .o_port_b(pb_out), .o_port_b_oe(pb_oe), .i_port_c(pc_in), .o_port_c(pc_out), .o_port_c_oe(pc_oe));

   // ------------------------------------------------------------
   // Report and comparison
   // ------------------------------------------------------------
   task summarize;
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   task cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // ------------------------------------------------------------
   // Classic single Wishbone cycle; waits for ack under a bound
   // ------------------------------------------------------------
   task bus(input logic w, input logic [11:0] idx, input logic [15:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'h3;
      wdat <= {16'h0000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t bus answer missing", $time);
         summarize();
      end else begin
         rd = rdat[15:0];
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
         // Extra idle edge covers the slave's wait state after ack
         @(posedge clk);
      end
   endtask : bus

   task wr(input logic [11:0] idx, input logic [15:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task rdc(input logic [11:0] idx, input logic [15:0] exp);
      bus(1'b0, idx, 16'h0000);
      cmp(rd, exp);
   endtask : rdc

   // Port C bits expected present: bits 1 and 3 need the mid package, 2 and 4 the large one;
   // lines 12 and 15 also depend on the oscillator fields
   function automatic logic [15:0] c_avail(input logic [1:0] pkgv, input logic [1:0] mode, input logic [1:0] fn);
      logic [15:0] m;
      m = (pkgv == 2'h0) ? 16'hF000 : (pkgv == 2'h1) ? 16'hF00A : 16'hF01E;
      if (mode == 2'h1 || mode == 2'h2) m = m & 16'h6FFF;
      if (fn != 2'h3) m[15] = 1'b0;
      return m;
   endfunction : c_avail

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      // Reset values and floating pins
      rdc(`GPBC_IDX_B_DIRECTION, 16'hFFFF);
      rdc(`GPBC_IDX_B_OPEN_DRAIN, 16'h0000);
      rdc(`GPBC_IDX_C_DIRECTION, 16'hF01E);
      rdc(`GPBC_IDX_C_OPEN_DRAIN, 16'h0000);
      cmp(pb_oe | pc_oe, 16'h0000);
      // Unmapped address and absent port C bits
      wr(12'h2C0, 16'hFFFF);
      rdc(12'h2C0, 16'h0000);
      wr(`GPBC_IDX_C_OPEN_DRAIN, 16'hFFFF);
      rdc(`GPBC_IDX_C_OPEN_DRAIN, 16'hF01E);
      wr(`GPBC_IDX_C_OPEN_DRAIN, 16'h0000);
      // Port B push-pull, then open drain on the low byte
      wr(`GPBC_IDX_B_DIRECTION, 16'h0000);
      wr(`GPBC_IDX_B_OUTPUT_LATCH, 16'hA5A5);
      cmp(pb_out, 16'hA5A5);
      cmp(pb_oe, 16'hFFFF);
      wr(`GPBC_IDX_B_OPEN_DRAIN, 16'h00FF);
      cmp(pb_out, 16'hA500);
      cmp(pb_oe, 16'hFF5A);
      wr(`GPBC_IDX_B_PIN_STATE, 16'h1234);
      rdc(`GPBC_IDX_B_OUTPUT_LATCH, 16'h1234);
      pb_in <= 16'h5AC3;
      // Input passes a two-stage synchroniser first
      repeat (3) @(posedge clk);
      rdc(`GPBC_IDX_B_PIN_STATE, 16'h5AC3);
      // Package variants with both oscillator fields at 11
      wr(`GPBC_IDX_C_DIRECTION, 16'h0000);
      pc_in <= 16'hFFFF;
      for (int p = 0; p < 3; p++) begin
         wr(`GPBC_IDX_CONFIG, {10'h000, p[1:0], 4'hF});
         wr(`GPBC_IDX_C_OUTPUT_LATCH, 16'hFFFF);
         rdc(`GPBC_IDX_C_OUTPUT_LATCH, c_avail(p[1:0], 2'h3, 2'h3));
         rdc(`GPBC_IDX_C_PIN_STATE, c_avail(p[1:0], 2'h3, 2'h3));
         cmp(pc_oe, c_avail(p[1:0], 2'h3, 2'h3));
         // Absent bits were never written, so the drive value shows only present ones
         cmp(pc_out, c_avail(p[1:0], 2'h3, 2'h3));
      end
      // Every oscillator mode and pin function code, large package
      for (int c = 0; c < 16; c++) begin
         wr(`GPBC_IDX_CONFIG, {10'h000, 2'h2, c[3:0]});
         wr(`GPBC_IDX_C_OUTPUT_LATCH, 16'hFFFF);
         rdc(`GPBC_IDX_C_OUTPUT_LATCH, c_avail(2'h2, c[1:0], c[3:2]));
         rdc(`GPBC_IDX_C_PIN_STATE, c_avail(2'h2, c[1:0], c[3:2]));
         cmp(pc_oe, c_avail(2'h2, c[1:0], c[3:2]));
      end
      // Second reset in mid-run restores direction and open-drain
      wr(`GPBC_IDX_B_DIRECTION, 16'h0000);
      wr(`GPBC_IDX_C_OPEN_DRAIN, 16'h0012);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rdc(`GPBC_IDX_B_DIRECTION, 16'hFFFF);
      rdc(`GPBC_IDX_C_OPEN_DRAIN, 16'h0000);
      summarize();
   end
endmodule : gpbc_top_tb
